// ===== core/ea_gen_defines.svh
// constant definitions for the effective address generator
// ****************************************************************
// Notes on behaviour
// ****************************************************************
// Notes on behaviour
// - Direct register mode passes the selected general register through as operand with no memory access.
// - Register indirect mode uses the selected general register unchanged as the address.
// - Post-increment addresses with the current register value, then writes back register plus 1, 2 or 4.
// - Pre-decrement subtracts 1, 2 or 4, writes that back and uses it as the address.
// - Register plus displacement zero-extends a 4-bit field, scales it by size and adds it to the register.
// - Indexed register mode adds index register zero to the selected register and writes neither back.
// - Base plus displacement zero-extends an 8-bit field, scales it by size and adds the global base pointer.
// - Indexed base mode adds index register zero to the global base pointer, changing neither.
// - PC-relative data load zero-extends an 8-bit field, doubles or quadruples it and adds the PC.
// - For a PC-relative longword the two low PC bits are cleared first; words use the PC unmasked.
`ifndef EA_GEN_DEFINES_SVH
`define EA_GEN_DEFINES_SVH
`define EA_WIDTH 32
`define EA_PC_LONG_MASK 32'hffff_fffc
`define EA_ADDR_RESET 32'h0000_0000
`define EA_LATENCY 1
`endif

// ===== core/ea_gen_pkg.sv
// types shared by the effective address generator
package ea_gen_pkg;
	// operand size encoding
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} op_size_t;
	// addressing mode encoding
	typedef enum logic [3:0] {
		AM_DIRECT = 4'h0,
		AM_INDIRECT = 4'h1,
		AM_POSTINC = 4'h2,
		AM_PREDEC = 4'h3,
		AM_DISP4 = 4'h4,
		AM_IDX_REG = 4'h5,
		AM_BASE_DISP = 4'h6,
		AM_BASE_IDX = 4'h7,
		AM_PC_DISP = 4'h8
	} addr_mode_t;
endpackage

// ===== core/ea_scale.sv
// displacement scaler: zero-extends and shifts by operand size
`timescale 1ns/1ps
`default_nettype none
`include "ea_gen_defines.svh"
module ea_scale
	import ea_gen_pkg::*;
(
	input wire logic [7:0] disp, // raw displacement field
	input wire logic wide, // use all 8 bits, else low 4
	input wire ea_gen_pkg::op_size_t size, // operand size
	output logic [`EA_WIDTH-1:0] scaled // scaled displacement
);
	import ea_gen_pkg::*;
	logic [`EA_WIDTH-1:0] ext;
	// zero extension; the 4-bit form drops the upper nibble
	always_comb begin
		ext = {24'h000000, wide ? disp : {4'h0, disp[3:0]}};
		case (size)
			SZ_WORD: scaled = {ext[`EA_WIDTH-2:0], 1'b0};
			SZ_LONG: scaled = {ext[`EA_WIDTH-3:0], 2'b00};
			default: scaled = ext;
		endcase
	end
endmodule
`default_nettype wire

// ===== core/ea_gen.sv
// effective address generator for core load, store and data instructions
`timescale 1ns/1ps
`default_nettype none
`include "ea_gen_defines.svh"
module ea_gen
	import ea_gen_pkg::*;
(
	input wire logic mclk, // core clock
	input wire logic reset, // synchronous, active high
	input wire logic req, // decoder presents an operand
	input wire ea_gen_pkg::addr_mode_t mode, // addressing mode
	input wire ea_gen_pkg::op_size_t size, // operand size
	input wire logic [7:0] disp, // displacement field
	input wire logic [`EA_WIDTH-1:0] selected_general_register, // register value
	input wire logic [`EA_WIDTH-1:0] index_register_zero, // index value
	input wire logic [`EA_WIDTH-1:0] global_base_pointer, // base value
	input wire logic [`EA_WIDTH-1:0] pc, // program counter
	output logic valid_r, // result valid, one cycle
	output logic mem_access_r, // address is for memory
	output logic [`EA_WIDTH-1:0] addr_r, // effective address
	output logic [`EA_WIDTH-1:0] operand_r, // direct operand
	output logic wb_en_r, // write back to register
	output logic [`EA_WIDTH-1:0] wb_data_r // write-back value
);
	import ea_gen_pkg::*;

	// ****************************************************************
	// helpers
	// ****************************************************************
	// size step of 1, 2 or 4
	function automatic logic [`EA_WIDTH-1:0] size_step(input op_size_t s);
		case (s)
			SZ_WORD: size_step = 32'h0000_0002;
			SZ_LONG: size_step = 32'h0000_0004;
			default: size_step = 32'h0000_0001;
		endcase
	endfunction
	// wrapping add; carry out is dropped on purpose
	function automatic logic [`EA_WIDTH-1:0] wrap_add(input logic [`EA_WIDTH-1:0] a, input logic [`EA_WIDTH-1:0] b);
		wrap_add = a + b;
	endfunction

	// ****************************************************************
	// datapath
	// ****************************************************************
	logic [`EA_WIDTH-1:0] scaled;
	logic wide;
	logic valid_nxt, mem_nxt, wb_en_nxt;
	logic [`EA_WIDTH-1:0] addr_nxt, operand_nxt, wb_data_nxt;

	assign wide = (mode != AM_DISP4);

	ea_scale u_scale (
		.disp(disp),
		.wide(wide),
		.size(size),
		.scaled(scaled)
	);

	// next-value computation for all outputs
	always_comb begin
		valid_nxt = req;
		mem_nxt = 1'b0;
		wb_en_nxt = 1'b0;
		addr_nxt = addr_r;
		operand_nxt = operand_r;
		wb_data_nxt = wb_data_r;
		if (req) begin
			mem_nxt = 1'b1;
			case (mode)
				AM_DIRECT: begin
					mem_nxt = 1'b0;
					operand_nxt = selected_general_register;
				end
				AM_INDIRECT: addr_nxt = selected_general_register;
				AM_POSTINC: begin
					addr_nxt = selected_general_register;
					wb_en_nxt = 1'b1;
					wb_data_nxt = wrap_add(selected_general_register, size_step(size));
				end
				AM_PREDEC: begin
					// borrow drops out the top
					addr_nxt = selected_general_register - size_step(size);
					wb_en_nxt = 1'b1;
					wb_data_nxt = selected_general_register - size_step(size);
				end
				AM_DISP4: addr_nxt = wrap_add(selected_general_register, scaled);
				AM_IDX_REG: addr_nxt = wrap_add(selected_general_register, index_register_zero);
				AM_BASE_DISP: addr_nxt = wrap_add(global_base_pointer, scaled);
				AM_BASE_IDX: addr_nxt = wrap_add(global_base_pointer, index_register_zero);
				AM_PC_DISP: begin
					// byte size is not a legal pc-relative load; treated as word
					if (size == SZ_LONG)
						addr_nxt = wrap_add(pc & `EA_PC_LONG_MASK, scaled);
					else if (size == SZ_WORD)
						addr_nxt = wrap_add(pc, scaled);
					else
						addr_nxt = wrap_add(pc, {scaled[`EA_WIDTH-2:0], 1'b0});
				end
				default: begin
					mem_nxt = 1'b0;
					valid_nxt = 1'b0;
				end
			endcase
		end
	end

	// output registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			valid_r <= 1'b0;
			mem_access_r <= 1'b0;
			wb_en_r <= 1'b0;
			addr_r <= `EA_ADDR_RESET;
			operand_r <= `EA_ADDR_RESET;
			wb_data_r <= `EA_ADDR_RESET;
		end else begin
			valid_r <= valid_nxt;
			mem_access_r <= mem_nxt;
			wb_en_r <= wb_en_nxt;
			addr_r <= addr_nxt;
			operand_r <= operand_nxt;
			wb_data_r <= wb_data_nxt;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	sequence s_req(addr_mode_t m);
		req && mode == m;
	endsequence
	// mode and size together; a sequence may not be an operand of a logical and
	sequence s_req_sz(addr_mode_t m, op_size_t s);
		req && mode == m && size == s;
	endsequence

	AST_DIRECT: assert property (@(posedge mclk) disable iff (reset)
		s_req(AM_DIRECT) |=> !mem_access_r && operand_r == $past(selected_general_register) && !wb_en_r)
		else $error("direct mode wrong");
	AST_INDIRECT: assert property (@(posedge mclk) disable iff (reset)
		s_req(AM_INDIRECT) |=> mem_access_r && addr_r == $past(selected_general_register) && !wb_en_r)
		else $error("indirect address wrong");
	AST_POSTINC: assert property (@(posedge mclk) disable iff (reset)
		s_req(AM_POSTINC) |=> addr_r == $past(selected_general_register) && wb_en_r
			&& wb_data_r - addr_r == size_step($past(size)))
		else $error("post-increment wrong");
	AST_PREDEC: assert property (@(posedge mclk) disable iff (reset)
		s_req(AM_PREDEC) |=> wb_en_r && wb_data_r == addr_r
			&& addr_r + size_step($past(size)) == $past(selected_general_register))
		else $error("pre-decrement wrong");
	AST_DISP4: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_DISP4, SZ_LONG) |=>
			addr_r == $past(selected_general_register) + {26'h0, $past(disp[3:0]), 2'b00})
		else $error("4-bit displacement wrong");
	AST_IDX_REG: assert property (@(posedge mclk) disable iff (reset)
		s_req(AM_IDX_REG) |=> !wb_en_r && addr_r == $past(selected_general_register) + $past(index_register_zero))
		else $error("indexed register wrong");
	AST_BASE_DISP: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_BASE_DISP, SZ_WORD) |=>
			addr_r == $past(global_base_pointer) + {23'h0, $past(disp), 1'b0})
		else $error("base displacement wrong");
	AST_BASE_IDX: assert property (@(posedge mclk) disable iff (reset)
		s_req(AM_BASE_IDX) |=> !wb_en_r && addr_r == $past(global_base_pointer) + $past(index_register_zero))
		else $error("indexed base wrong");
	AST_PC_WORD: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_PC_DISP, SZ_WORD) |=> addr_r == $past(pc) + {23'h0, $past(disp), 1'b0})
		else $error("pc word address wrong");
	AST_PC_LONG: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_PC_DISP, SZ_LONG) |=> addr_r[1:0] == 2'b00
			&& addr_r == {$past(pc[31:2]), 2'b00} + {22'h0, $past(disp), 2'b00})
		else $error("pc long address wrong");
	AST_WRAP: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_POSTINC, SZ_WORD) ##0 (selected_general_register == 32'hffff_fffe)
			|=> wb_data_r == 32'h0000_0000)
		else $error("wrap-around wrong");
	AST_VALID: assert property (@(posedge mclk) disable iff (reset)
		!req |=> !valid_r && !wb_en_r)
		else $error("spurious valid");
	AST_BORROW: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_PREDEC, SZ_LONG) ##0 (selected_general_register == 32'h0000_0002)
			|=> addr_r == 32'hffff_fffe && wb_data_r == 32'hffff_fffe)
		else $error("pre-decrement borrow wrong");

	// ****************************************************************
	// per-size scaling, refusal and holding
	// ****************************************************************
	// an undefined mode code is dropped; nothing may move
	sequence s_refused;
		req && mode > AM_PC_DISP;
	endsequence
	AST_REFUSED: assert property (@(posedge mclk) disable iff (reset)
		s_refused |=> !valid_r && !mem_access_r && !wb_en_r
			&& $stable(addr_r) && $stable(operand_r) && $stable(wb_data_r))
		else $error("refused request changed outputs");
	AST_LEGAL_VALID: assert property (@(posedge mclk) disable iff (reset)
		req && mode <= AM_PC_DISP |=> valid_r)
		else $error("legal request not answered");
	AST_MEM_QUAL: assert property (@(posedge mclk) disable iff (reset)
		mem_access_r |-> valid_r)
		else $error("memory access without valid");
	// results stand until the next request, so the consumer may sample late
	AST_HOLD: assert property (@(posedge mclk) disable iff (reset)
		!req |=> !mem_access_r && $stable(addr_r) && $stable(operand_r) && $stable(wb_data_r))
		else $error("outputs moved without a request");
	AST_DIRECT_HOLD: assert property (@(posedge mclk) disable iff (reset)
		s_req(AM_DIRECT) |=> $stable(addr_r) && $stable(wb_data_r))
		else $error("direct mode touched the address");
	AST_DISP4_BYTE: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_DISP4, SZ_BYTE) |=>
			addr_r == $past(selected_general_register) + {28'h0, $past(disp[3:0])})
		else $error("4-bit byte displacement wrong");
	AST_DISP4_WORD: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_DISP4, SZ_WORD) |=>
			addr_r == $past(selected_general_register) + {27'h0, $past(disp[3:0]), 1'b0})
		else $error("4-bit word displacement wrong");
	AST_BASE_DISP_BYTE: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_BASE_DISP, SZ_BYTE) |=>
			addr_r == $past(global_base_pointer) + {24'h0, $past(disp)})
		else $error("base byte displacement wrong");
	AST_BASE_DISP_LONG: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_BASE_DISP, SZ_LONG) |=>
			addr_r == $past(global_base_pointer) + {22'h0, $past(disp), 2'b00})
		else $error("base long displacement wrong");
	// byte size has no pc-relative meaning; it follows the word form
	AST_PC_BYTE: assert property (@(posedge mclk) disable iff (reset)
		s_req_sz(AM_PC_DISP, SZ_BYTE) |=>
			addr_r == $past(pc) + {23'h0, $past(disp), 1'b0})
		else $error("pc byte address wrong");
endmodule
`default_nettype wire

// ===== tb/ea_regfile_model.sv
// register file model holding the selected general register
`timescale 1ns/1ps
`default_nettype none
module ea_regfile_model (
	input wire logic mclk, // core clock
	input wire logic set_en, // bench loads a value
	input wire logic [31:0] set_val, // value to load
	input wire logic wb_en, // write-back strobe
	input wire logic [31:0] wb_data, // write-back value
	output logic [31:0] gr // selected register
);
	// write-back lands at the edge that ends the pulse
	always_ff @(posedge mclk) begin
		if (set_en) gr <= set_val;
		else if (wb_en) gr <= wb_data;
	end
endmodule
`default_nettype wire

// ===== tb/tb_cpu_effective_address_generator.sv
// self-checking bench for the effective address generator
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_effective_address_generator;
	import ea_gen_pkg::*;
	logic mclk, reset, req, set_en, valid_r, mem_access_r, wb_en_r;
	addr_mode_t mode;
	op_size_t size;
	logic [7:0] disp;
	logic [31:0] index_zero, base_ptr, pc, set_val, gr, addr_r, operand_r, wb_data_r;
	int errors, num_checks;
	ea_gen ea_gen_i (.mclk(mclk), .reset(reset), .req(req), .mode(mode), .size(size), .disp(disp),
		.selected_general_register(gr), .index_register_zero(index_zero), .global_base_pointer(base_ptr), .pc(pc),
		.valid_r(valid_r), .mem_access_r(mem_access_r), .addr_r(addr_r), .operand_r(operand_r),
		.wb_en_r(wb_en_r), .wb_data_r(wb_data_r));
	ea_regfile_model ea_regfile_model_i (.mclk(mclk), .set_en(set_en), .set_val(set_val),
		.wb_en(wb_en_r), .wb_data(wb_data_r), .gr(gr));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [31:0] sc(input op_size_t s);
		return (s == SZ_LONG) ? 32'h4 : (s == SZ_WORD) ? 32'h2 : 32'h1;
	endfunction
	// load register, one request, judge the answer and the register afterwards
	task automatic op(input addr_mode_t m, input op_size_t s, input logic [7:0] d, input logic [31:0] g,
		input logic ma, input logic [31:0] ea, input logic wb, input logic [31:0] wd);
		@(posedge mclk);
		set_en <= 1'b1;
		set_val <= g;
		@(posedge mclk);
		set_en <= 1'b0;
		req <= 1'b1;
		mode <= m;
		size <= s;
		disp <= d;
		@(posedge mclk);
		req <= 1'b0;
		#1;
		chk("valid", 32'h1, valid_r);
		chk("mem_access", {31'h0, ma}, mem_access_r);
		if (ma) chk("addr", ea, addr_r);
		else chk("operand", ea, operand_r);
		chk("wb_en", {31'h0, wb}, wb_en_r);
		if (wb) chk("wb_data", wd, wb_data_r);
		// register must change only where the mode writes back
		@(posedge mclk);
		#1;
		chk("register", wb ? wd : g, gr);
	endtask
	task automatic t_reg_modes();
		op(AM_DIRECT, SZ_LONG, 8'h00, 32'h1234_5678, 1'b0, 32'h1234_5678, 1'b0, 32'h0);
		op(AM_INDIRECT, SZ_BYTE, 8'hff, 32'h8000_0001, 1'b1, 32'h8000_0001, 1'b0, 32'h0);
	endtask
	task automatic t_update();
		op_size_t s;
		for (int i = 0; i < 3; i++) begin
			s = op_size_t'(i);
			op(AM_POSTINC, s, 8'h0, 32'hffff_fffe, 1'b1, 32'hffff_fffe, 1'b1, 32'hffff_fffe + sc(s));
			op(AM_PREDEC, s, 8'h0, 32'h2, 1'b1, 32'h2 - sc(s), 1'b1, 32'h2 - sc(s));
		end
	endtask
	task automatic t_disp();
		op_size_t s;
		for (int i = 0; i < 3; i++) begin
			s = op_size_t'(i);
			op(AM_DISP4, s, 8'hfb, 32'h1000, 1'b1, 32'h1000 + 32'hb * sc(s), 1'b0, 32'h0);
			op(AM_BASE_DISP, s, 8'hff, 32'h7, 1'b1, base_ptr + 32'hff * sc(s), 1'b0, 32'h0);
		end
	endtask
	task automatic t_index();
		op(AM_IDX_REG, SZ_WORD, 8'h0, 32'hffff_fff8, 1'b1, 32'h8, 1'b0, 32'h0);
		op(AM_BASE_IDX, SZ_LONG, 8'h0, 32'h5, 1'b1, 32'hffff_ff10, 1'b0, 32'h0);
	endtask
	task automatic t_pc();
		op(AM_PC_DISP, SZ_WORD, 8'h80, 32'h0, 1'b1, 32'h1103, 1'b0, 32'h0);
		op(AM_PC_DISP, SZ_LONG, 8'h80, 32'h0, 1'b1, 32'h1200, 1'b0, 32'h0);
		op(AM_PC_DISP, SZ_BYTE, 8'h80, 32'h0, 1'b1, 32'h1103, 1'b0, 32'h0);
	endtask
	// an unknown mode must leave every output quiet
	task automatic t_illegal();
		op(AM_INDIRECT, SZ_LONG, 8'h0, 32'habc, 1'b1, 32'habc, 1'b0, 32'h0);
		@(posedge mclk);
		req <= 1'b1;
		mode <= addr_mode_t'(4'h9);
		@(posedge mclk);
		req <= 1'b0;
		#1;
		chk("valid", 32'h0, valid_r);
		chk("addr", 32'habc, addr_r);
		chk("mem_access", 32'h0, mem_access_r);
		chk("wb_en", 32'h0, wb_en_r);
		// last direct operand and last write-back value must survive the refusal
		chk("operand", 32'h1234_5678, operand_r);
		chk("wb_data", 32'hffff_fffe, wb_data_r);
	endtask
	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		reset = 1'b1;
		req = 1'b0;
		set_en = 1'b0;
		set_val = 32'h0;
		mode = AM_DIRECT;
		size = SZ_BYTE;
		disp = 8'h0;
		index_zero = 32'h10;
		base_ptr = 32'hffff_ff00;
		pc = 32'h1003;
		errors = 0;
		num_checks = 0;
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		t_reg_modes();
		t_update();
		t_disp();
		t_index();
		t_pc();
		t_illegal();
		report_and_stop();
	end
	// cut a hang short well beyond the roughly ninety cycles the tests need
	initial begin
		#20us;
		errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
